// ===== rtl/analog_probe_and_trim_regs.sv
// register bank for converter control, probe selection and factory trim words
// assumes synchronous strobes from one master; trim words arrive as factory straps
//
// Operation
// - bits 7:2 of converter control select source; 0-31 internal, 32 ground
// - codes 56 to 63 route external inputs zero to seven
// - codes 20, 21, 24 select 4096, 2048, 1024 mV references
// - writing one to bit 1 with bit 0 also set starts conversion; reads one while busy
// - hardware clears conversion flag when conversion finishes
// - bit 0 powers converter; clear shuts it off
// - channel-2 block control at 10Dh; bits 6:4 digital probe selector
// - channel-2 bit 2 disables current-loop amplifier, clamps high
// - channel-2 bit 1 disables voltage-loop amplifier, clamps high
// - channel-2 bits 7, 3, 0 read zero
// - locations 2080h to 208Fh hold read-only factory calibration
// - word 2080h: channel-1 offset 13:8, current 7:4, voltage 3:0
// - word 2081h holds same fields for channel 2
// - six-bit offset: 0 and 32 mid, 31 max positive, 63 max negative
// - four-bit trim: 0 and 8 mid, 7 max positive, 15 max negative
// - selector also drives analog probe; pin enabled by channel-1 control
// - digital probe steered by group selector and channel-2 selector
// - channel-1 bit 7 connects digital probe to its pin
`timescale 1ns/1ps
`include "probe_trim_consts.svh"
module analog_probe_and_trim_regs
	import probe_trim_pkg::*;
#(
	parameter int CONV_CYCLES = `CONV_CYCLES,
	parameter int TRIM_WORDS = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire logic [13:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [13:0] regRdata,
	input wire logic [13:0] factoryTrim [TRIM_WORDS],
	output logic [5:0] sourceSelector,
	output logic [1:0] routeKind,
	output logic [2:0] externalInputIdx,
	output logic [2:0] referenceSel,
	output logic converterPower,
	output logic convStart,
	output logic convBusy,
	output logic analogProbePinEn,
	output logic [1:0] digitalProbeGroupSelector,
	output logic [2:0] digitalProbeSelector,
	output logic digitalProbePinEnable,
	output logic currentLoopAmpOffCh2,
	output logic voltageLoopAmpOffCh2,
	output logic signed [5:0] csOffsetCh1,
	output logic signed [3:0] iGmCh1,
	output logic signed [3:0] vGmCh1,
	output logic signed [5:0] csOffsetCh2,
	output logic signed [3:0] iGmCh2,
	output logic signed [3:0] vGmCh2
);
	////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rstSync1_reg;
	logic rstSync2_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1_reg <= 1'b0;
			rstSync2_reg <= 1'b0;
		end else begin
			rstSync1_reg <= 1'b1;
			rstSync2_reg <= rstSync1_reg;
		end
	end
	wire logic rstInt_n = rstSync2_reg;

	////////////////////////////////////////////////////////////////////////////
	// trim decode: sign and magnitude, so all-ones is the largest negative step
	function automatic logic signed [5:0] trim6(input logic [5:0] c);
		logic signed [5:0] mag;
		mag = $signed({1'b0, c[4:0]});
		trim6 = c[5] ? -mag : mag;
	endfunction : trim6
	function automatic logic signed [3:0] trim4(input logic [3:0] c);
		logic signed [3:0] mag;
		mag = $signed({1'b0, c[2:0]});
		trim4 = c[3] ? -mag : mag;
	endfunction : trim4

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] convCtrl_reg;
	logic [7:0] blkCh1_reg;
	logic [7:0] blkCh2_reg;
	logic [5:0] csTrimCh1_reg;
	logic [7:0] gmTrimCh1_reg;
	logic [5:0] csTrimCh2_reg;
	logic [7:0] gmTrimCh2_reg;
	logic [13:0] rdata_reg;
	logic [15:0] convCnt_reg;
	conv_state_e convState_reg;
	logic convDone;

	wire logic wrConv = regWr && regAddr == `OFS_CONV_CTRL;
	wire logic goSet = wrConv && regWdata[`CONV_GO_BIT];
	assign convDone = convState_reg == CONV_BUSY && convCnt_reg == 16'h0000;

	// selector, power and go fields; go bit cleared on conversion done or power-down write
	always_ff @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			convCtrl_reg <= `REG_RESET;
		end else if (clkEn) begin
			if (wrConv) begin
				convCtrl_reg[`CONV_SEL_HI:`CONV_SEL_LO] <= regWdata[`CONV_SEL_HI:`CONV_SEL_LO];
				convCtrl_reg[`CONV_PWR_BIT] <= regWdata[`CONV_PWR_BIT];
			end
			// start beats done in the same cycle
			if (goSet && regWdata[`CONV_PWR_BIT]) begin
				convCtrl_reg[`CONV_GO_BIT] <= 1'b1;
			end else if (convDone || (wrConv && !regWdata[`CONV_PWR_BIT])) begin
				convCtrl_reg[`CONV_GO_BIT] <= 1'b0;
			end
		end
	end

	// conversion timer; powering down aborts a conversion
	always_ff @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			convState_reg <= CONV_IDLE;
			convCnt_reg <= 16'h0000;
		end else if (clkEn) begin
			case (convState_reg)
				CONV_IDLE: begin
					if (goSet && regWdata[`CONV_PWR_BIT]) begin
						convState_reg <= CONV_BUSY;
						convCnt_reg <= 16'(CONV_CYCLES - 1);
					end
				end
				CONV_BUSY: begin
					if (wrConv && !regWdata[`CONV_PWR_BIT]) begin
						convState_reg <= CONV_IDLE;
					end else if (goSet) begin
						convCnt_reg <= 16'(CONV_CYCLES - 1);
					end else if (convCnt_reg == 16'h0000) begin
						convState_reg <= CONV_IDLE;
					end else begin
						convCnt_reg <= convCnt_reg - 16'h0001;
					end
				end
				default: begin
					convState_reg <= CONV_IDLE;
				end
			endcase
		end
	end

	// block controls and trim targets; calibration range has no write path
	always_ff @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			blkCh1_reg <= `REG_RESET;
			blkCh2_reg <= `REG_RESET;
			csTrimCh1_reg <= 6'h00;
			gmTrimCh1_reg <= 8'h00;
			csTrimCh2_reg <= 6'h00;
			gmTrimCh2_reg <= 8'h00;
		end else if (clkEn && regWr) begin
			case (regAddr)
				`OFS_BLK_CH1: blkCh1_reg <= regWdata[7:0];
				`OFS_BLK_CH2: blkCh2_reg <= regWdata[7:0] & `CH2_IMPL_MASK;
				`OFS_CS_TRIM_CH1: csTrimCh1_reg <= regWdata[5:0];
				`OFS_GM_TRIM_CH1: gmTrimCh1_reg <= regWdata[7:0];
				`OFS_CS_TRIM_CH2: csTrimCh2_reg <= regWdata[5:0];
				`OFS_GM_TRIM_CH2: gmTrimCh2_reg <= regWdata[7:0];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port, data valid the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			rdata_reg <= 14'h0000;
		end else if (clkEn) begin
			if (!regRd) begin
				rdata_reg <= 14'h0000;
			end else if (regAddr >= `OFS_TRIM_FIRST && regAddr <= `OFS_TRIM_LAST) begin
				rdata_reg <= factoryTrim[4'(regAddr - `OFS_TRIM_FIRST)];
			end else begin
				case (regAddr)
					`OFS_CONV_CTRL: rdata_reg <= {6'h00, convCtrl_reg};
					`OFS_BLK_CH1: rdata_reg <= {6'h00, blkCh1_reg};
					`OFS_BLK_CH2: rdata_reg <= {6'h00, blkCh2_reg & `CH2_IMPL_MASK};
					`OFS_CS_TRIM_CH1: rdata_reg <= {8'h00, csTrimCh1_reg};
					`OFS_GM_TRIM_CH1: rdata_reg <= {6'h00, gmTrimCh1_reg};
					`OFS_CS_TRIM_CH2: rdata_reg <= {8'h00, csTrimCh2_reg};
					`OFS_GM_TRIM_CH2: rdata_reg <= {6'h00, gmTrimCh2_reg};
					default: rdata_reg <= 14'h0000;
				endcase
			end
		end
	end
	assign regRdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// source routing decode
	logic [5:0] sel;
	always_comb begin
		sel = convCtrl_reg[`CONV_SEL_HI:`CONV_SEL_LO];
		externalInputIdx = 3'h0;
		referenceSel = 3'h0;
		if (sel < `SEL_GND_NODE) begin
			routeKind = ROUTE_INTERNAL;
		end else if (sel == `SEL_GND_NODE) begin
			routeKind = ROUTE_GROUND;
		end else if (sel >= `SEL_EXT_BASE) begin
			routeKind = ROUTE_EXTERNAL;
			externalInputIdx = sel[2:0];
		end else begin
			routeKind = ROUTE_NONE;
		end
		// one-hot: 4096, 2048, 1024 mV
		referenceSel[2] = sel == `SEL_REF_4096;
		referenceSel[1] = sel == `SEL_REF_2048;
		referenceSel[0] = sel == `SEL_REF_1024;
	end

	assign sourceSelector = sel;
	assign analogProbePinEn = blkCh1_reg[`CH1_ANAEN_BIT];
	assign converterPower = convCtrl_reg[`CONV_PWR_BIT];
	assign convBusy = convState_reg == CONV_BUSY;
	assign convStart = clkEn && goSet && regWdata[`CONV_PWR_BIT] && convState_reg == CONV_IDLE;
	assign digitalProbeGroupSelector = blkCh1_reg[`CH1_GRP_HI:`CH1_GRP_LO];
	assign digitalProbeSelector = blkCh2_reg[`CH2_DSEL_HI:`CH2_DSEL_LO];
	assign digitalProbePinEnable = blkCh1_reg[`CH1_PINEN_BIT];
	assign currentLoopAmpOffCh2 = blkCh2_reg[`CH2_IAMP_BIT];
	assign voltageLoopAmpOffCh2 = blkCh2_reg[`CH2_VAMP_BIT];

	////////////////////////////////////////////////////////////////////////////
	// trims act only once firmware loads them
	assign csOffsetCh1 = trim6(csTrimCh1_reg);
	assign iGmCh1 = trim4(gmTrimCh1_reg[`TRIM_I_HI:`TRIM_I_LO]);
	assign vGmCh1 = trim4(gmTrimCh1_reg[`TRIM_V_HI:`TRIM_V_LO]);
	assign csOffsetCh2 = trim6(csTrimCh2_reg);
	assign iGmCh2 = trim4(gmTrimCh2_reg[`TRIM_I_HI:`TRIM_I_LO]);
	assign vGmCh2 = trim4(gmTrimCh2_reg[`TRIM_V_HI:`TRIM_V_LO]);
endmodule : analog_probe_and_trim_regs

// ===== rtl/probe_trim_consts.svh
// register offsets, field positions, reset values and timing counts for the probe/trim bank
// assumes inclusion by the register bank module only
`ifndef PROBE_TRIM_CONSTS_SVH
`define PROBE_TRIM_CONSTS_SVH
`define ADDR_W 14
`define OFS_CONV_CTRL 14'h010f
`define OFS_BLK_CH1 14'h010c
`define OFS_BLK_CH2 14'h010d
`define OFS_TRIM_FIRST 14'h2080
`define OFS_TRIM_LAST 14'h208f
`define OFS_TRIM_CH1 14'h2080
`define OFS_TRIM_CH2 14'h2081
`define OFS_CS_TRIM_CH1 14'h0110
`define OFS_GM_TRIM_CH1 14'h0111
`define OFS_CS_TRIM_CH2 14'h0112
`define OFS_GM_TRIM_CH2 14'h0113
`define CONV_SEL_HI 7
`define CONV_SEL_LO 2
`define CONV_GO_BIT 1
`define CONV_PWR_BIT 0
`define CH2_DSEL_HI 6
`define CH2_DSEL_LO 4
`define CH2_IAMP_BIT 2
`define CH2_VAMP_BIT 1
`define CH2_IMPL_MASK 8'h76
`define CH1_PINEN_BIT 7
`define CH1_GRP_HI 5
`define CH1_GRP_LO 4
`define CH1_ANAEN_BIT 0
`define TRIM_CS_HI 13
`define TRIM_CS_LO 8
`define TRIM_I_HI 7
`define TRIM_I_LO 4
`define TRIM_V_HI 3
`define TRIM_V_LO 0
`define REG_RESET 8'h00
`define SEL_GND_NODE 6'h20
`define SEL_EXT_BASE 6'h38
`define SEL_REF_4096 6'h14
`define SEL_REF_2048 6'h15
`define SEL_REF_1024 6'h18
`define CONV_TIME_NS 2000
`define CLK_PERIOD_NS 25
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== rtl/probe_trim_pkg.sv
// types shared by the probe/trim register bank
// assumes the constants header sits beside it
package probe_trim_pkg;
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_BUSY = 2'b01
	} conv_state_e;
	typedef enum logic [1:0] {
		ROUTE_INTERNAL = 2'b00,
		ROUTE_GROUND = 2'b01,
		ROUTE_EXTERNAL = 2'b10,
		ROUTE_NONE = 2'b11
	} route_kind_e;
	typedef logic [5:0] sel_t;
endpackage : probe_trim_pkg

// ===== verif/analog_probe_and_trim_regs_assertions.sv
// port checker for the probe/trim register bank
// assumes a bind from the bench top, one clock domain
`timescale 1ns/1ps
module analog_probe_and_trim_regs_assertions #(
	parameter int CONV_CYCLES = 80
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [13:0] regAddr,
	input wire logic [13:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [13:0] regRdata,
	input wire logic [5:0] sourceSelector,
	input wire logic [1:0] routeKind,
	input wire logic [2:0] externalInputIdx,
	input wire logic [2:0] referenceSel,
	input wire logic convStart,
	input wire logic convBusy,
	input wire logic [2:0] digitalProbeSelector,
	input wire logic currentLoopAmpOffCh2,
	input wire logic voltageLoopAmpOffCh2
);
////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence startSeq;
		clkEn && convStart;
	endsequence
	sequence ch2Wr;
		clkEn && regWr && regAddr == 14'h010d;
	endsequence
	// a counter, since the busy span is a parameter
	int busyCnt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			busyCnt <= 0;
		else if (!convBusy || convStart)
			busyCnt <= 0;
		else if (clkEn)
			busyCnt <= busyCnt + 1;
	end
////////////////////////////////////////////////////////////////
	AST_START_BUSY: assert property (startSeq |=> convBusy)
		else $error("busy missing after start");
	AST_BUSY_LEN: assert property (convBusy |-> busyCnt <= CONV_CYCLES + 1)
		else $error("conversion flag never cleared");
	AST_SEL_WR: assert property (clkEn && regWr && regAddr == 14'h010f |=> sourceSelector == $past(regWdata[7:2]))
		else $error("selector not written");
	AST_CH2_SEL: assert property (ch2Wr |=> digitalProbeSelector == $past(regWdata[6:4]))
		else $error("probe selector not written");
	AST_AMP_OFF: assert property (ch2Wr |=> {currentLoopAmpOffCh2, voltageLoopAmpOffCh2} == $past(regWdata[2:1]))
		else $error("amplifier disable bits wrong");
	AST_RD_CH2: assert property (clkEn && regRd && regAddr == 14'h010d |=> (regRdata & 14'h3f89) == 14'h0)
		else $error("unimplemented bits read nonzero");
	AST_EXT: assert property (sourceSelector[5:3] == 3'h7 |-> routeKind == 2'h2 && externalInputIdx == sourceSelector[2:0])
		else $error("external input routing wrong");
	AST_GND: assert property (sourceSelector == 6'h20 |-> routeKind == 2'h1)
		else $error("ground node not routed");
	AST_REF: assert property (referenceSel == {sourceSelector == 6'h14, sourceSelector == 6'h15, sourceSelector == 6'h18})
		else $error("reference select wrong");
endmodule : analog_probe_and_trim_regs_assertions

// ===== verif/analog_probe_and_trim_regs_bench.sv
// self-checking bench for the probe/trim register bank
// assumes the bank, its package and the checker compile first
`timescale 1ns/1ps
module analog_probe_and_trim_regs_bench;
	localparam int CC = 4;
	logic ref_clk = 1'h0, rst_n = 1'h0, clkEn = 1'h0, regWr = 1'h0, regRd = 1'h0;
	logic [13:0] regAddr = 14'h0, regWdata = 14'h0, regRdata;
	logic [13:0] factoryTrim [16];
	logic [5:0] sourceSelector;
	logic [1:0] routeKind, digitalProbeGroupSelector;
	logic [2:0] externalInputIdx, referenceSel, digitalProbeSelector;
	logic converterPower, convStart, convBusy, analogProbePinEn, digitalProbePinEnable;
	logic currentLoopAmpOffCh2, voltageLoopAmpOffCh2;
	logic signed [5:0] csOffsetCh1, csOffsetCh2;
	logic signed [3:0] iGmCh1, vGmCh1, iGmCh2, vGmCh2;
	int mismatches = 0, n_tests = 0;
	analog_probe_and_trim_regs #(.CONV_CYCLES(CC)) dut_u (.*);
	always #12.5 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [13:0] a, input logic [13:0] d);
		@(posedge ref_clk);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'h0;
		#1;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [13:0] a, input logic [13:0] exp);
		@(posedge ref_clk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'h0;
		#1;
		check("regRdata", regRdata, exp);
	endtask : rd
////////////////////////////////////////////////////////////////
	task automatic t_route;
		logic [5:0] codes [7] = '{6'h14, 6'h15, 6'h18, 6'h20, 6'h38, 6'h3d, 6'h1f};
		logic [5:0] c;
		for (int i = 0; i < 7; i++) begin
			c = codes[i];
			wr(14'h010f, {6'h0, c, 2'h1});
			rd(14'h010f, {6'h0, c, 2'h1});
			check("routeKind", 14'(routeKind), c == 6'h20 ? 14'h1 : c[5:3] == 3'h7 ? 14'h2 : 14'h0);
			check("extIdx", 14'(externalInputIdx), c[5:3] == 3'h7 ? 14'(c[2:0]) : 14'h0);
			check("referenceSel", 14'(referenceSel), {11'h0, c == 6'h14, c == 6'h15, c == 6'h18});
			check("converterPower", 14'(converterPower), 14'h1);
		end
		wr(14'h010f, 14'h0000);
		check("converterPower", 14'(converterPower), 14'h0);
	endtask : t_route
	task automatic t_conv;
		int n = 0;
		wr(14'h010f, 14'h00e3);
		check("convBusy", 14'(convBusy), 14'h1);
		rd(14'h010f, 14'h00e3);
		// bounded wait so a stuck flag cannot hang the run
		while (convBusy === 1'h1 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		rd(14'h010f, 14'h00e1);
		check("convBusy", 14'(convBusy), 14'h0);
	endtask : t_conv
	task automatic t_blocks;
		wr(14'h010d, 14'h3fff);
		rd(14'h010d, 14'h0076);
		check("probeSel", 14'(digitalProbeSelector), 14'h7);
		check("ampOff", {12'h0, currentLoopAmpOffCh2, voltageLoopAmpOffCh2}, 14'h3);
		wr(14'h010d, 14'h002a);
		rd(14'h010d, 14'h0022);
		check("ampOff", {12'h0, currentLoopAmpOffCh2, voltageLoopAmpOffCh2}, 14'h1);
		wr(14'h010c, 14'h00b1);
		check("probePins", {11'h0, digitalProbePinEnable, digitalProbeGroupSelector}, 14'h7);
		check("analogPin", 14'(analogProbePinEn), 14'h1);
	endtask : t_blocks
	task automatic t_trim;
		for (int i = 0; i < 16; i++)
			rd(14'h2080 + 14'(i), 14'h0111 * 14'(i) + 14'h0025);
		wr(14'h2080, 14'h0000);
		rd(14'h2080, 14'h0025);
		rd(14'h0200, 14'h0000);
		wr(14'h0110, 14'h0020);
		check("csOffsetCh1", 14'(csOffsetCh1), 14'h0);
		wr(14'h0112, 14'h003f);
		check("csOffsetCh2", 14'(csOffsetCh2), 14'h3fe1);
		wr(14'h0113, 14'h00ff);
		check("gmCh2", {6'h0, iGmCh2, vGmCh2}, 14'h99);
		wr(14'h0110, 14'h001f);
		check("csOffsetCh1", 14'(csOffsetCh1), 14'h1f);
		wr(14'h0111, 14'h0087);
		check("gmCh1", {6'h0, iGmCh1, vGmCh1}, 14'h07);
		wr(14'h0113, 14'h0078);
		check("gmCh2", {6'h0, iGmCh2, vGmCh2}, 14'h70);
	endtask : t_trim
////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 16; i++)
			factoryTrim[i] = 14'h0111 * 14'(i) + 14'h0025;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		clkEn <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rd(14'h010f, 14'h0000);
		rd(14'h010d, 14'h0000);
		t_route();
		t_conv();
		t_blocks();
		t_trim();
		conclude();
	end
	initial begin
		#50000;
		mismatches++;
		conclude();
	end
endmodule : analog_probe_and_trim_regs_bench
bind analog_probe_and_trim_regs analog_probe_and_trim_regs_assertions #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.*);
